// ---- logic/acc_switch_pkg.sv ----
// constants and types shared by the accessory switch ends
// What this block does
// R1 - indicator low when charger found
// R2 - detection runs only with valid vbus
// R3 - dedicated and downstream charging ports reported
// R4 - contact detect precedes charger typing
// R5 - detect only with all paths open
// R6 - keep paths open until detection done
// R7 - no contact: 000 to usb stays open
// R8 - audio code then usb lifts blocking
// R9 - vbus and contact glitches filtered by timing
// R10 - hold 111 thirty us resets detection
// R11 - after reset, 000 held restarts detection
// R12 - host re-arms after low battery recovery
// R13 - host phy waits for detection done; host only holds 000 for HOLD_CYCLES and has no detection done input
// R14 - host opens paths before other usb
// R15 - 000 opens all, low power
// R16 - 001 joins first usb port, default
// R17 - 010 joins second usb port
// R18 - 011 right/left audio, no microphone
// R19 - 100 microphone plus, left minus
// R20 - 101 stereo audio, microphone on vbus
// R21 - host never drives code 110
// R22 - audio lines terminated to ground when both are open
// R23 - hold timer restarts on select change
package acc_switch_pkg;
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned HOLD_US         = 30;
    localparam int unsigned HOLD_CYCLES     = (HOLD_US * CLK_HZ + 999_999)
                                              / 1_000_000;
    localparam int unsigned DEB_US          = 10;
    localparam int unsigned DEB_CYCLES      = (DEB_US * CLK_HZ + 999_999)
                                              / 1_000_000;
    localparam int unsigned CNT_W           = 12;
    localparam logic [2:0]  SEL_OPEN        = 3'h0;
    localparam logic [2:0]  SEL_USB_A       = 3'h1;
    localparam logic [2:0]  SEL_USB_B       = 3'h2;
    localparam logic [2:0]  SEL_AUDIO       = 3'h3;
    localparam logic [2:0]  SEL_MONO_MIC    = 3'h4;
    localparam logic [2:0]  SEL_STEREO_MIC  = 3'h5;
    localparam logic [2:0]  SEL_RESERVED    = 3'h6;
    localparam logic [2:0]  SEL_DET_RESET   = 3'h7;
    localparam logic [2:0]  SEL_RESET_VALUE = 3'h1;
    // path enable bits
    localparam int unsigned P_USB_A = 0;
    localparam int unsigned P_USB_B = 1;
    localparam int unsigned P_R_PLUS = 2;
    localparam int unsigned P_L_MINUS = 3;
    localparam int unsigned P_MIC_PLUS = 4;
    localparam int unsigned P_MIC_VBUS = 5;
    localparam int unsigned P_TERM = 6;
    localparam int unsigned PATH_W = 7;
    localparam logic [PATH_W-1:0] PATH_RESET = 7'h40;
    typedef enum logic [2:0] {
        DET_DISARMED, DET_IDLE, DET_CONTACT, DET_TYPE, DET_DONE
    } det_state_t;
endpackage

// ---- logic/acc_switch_if.sv ----
// select and indicator wires between host and switch
`timescale 1ns/1ps
interface acc_switch_if;
    logic [2:0] sel;
    logic       charger_found_n_o;
    logic       charger_found_n_oe;
    logic       charger_found_n;
    // open drain with external pull-up
    assign charger_found_n = charger_found_n_oe ? charger_found_n_o : 1'b1;
    modport device (input sel, output charger_found_n_o, charger_found_n_oe);
    modport host   (output sel, input charger_found_n);
endinterface

// ---- logic/acc_switch_dev.sv ----
// accessory switch control: path select and charger detection
`timescale 1ns/1ps
module acc_switch_dev (
    input  wire logic                clock,
    input  wire logic                reset,
    acc_switch_if.device             link,
    input  wire logic                vbus_valid,
    input  wire logic                contact_seen,
    input  wire logic                charger_port_seen,
    output logic [acc_switch_pkg::PATH_W-1:0] path_en,
    output logic                     detect_busy,
    output logic                     low_power
);
    logic [2:0] sel_s1_ff, sel_s2_ff, sel_s3_ff, sel_ff;
    logic [2:0] vb_sync_ff;
    logic [2:0] ct_sync_ff;
    logic [2:0] ch_sync_ff;
    logic       vbus_ff, contact_ff, chport_ff;
    logic [acc_switch_pkg::CNT_W-1:0] hold_cnt_ff;
    logic [acc_switch_pkg::CNT_W-1:0] deb_cnt_ff;
    logic       held_ff;
    logic       block_ff;
    logic       found_ff;
    logic [acc_switch_pkg::PATH_W-1:0] nxt_path;
    acc_switch_pkg::det_state_t state_ff;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            sel_s1_ff <= acc_switch_pkg::SEL_RESET_VALUE;
            sel_s2_ff <= acc_switch_pkg::SEL_RESET_VALUE;
            sel_s3_ff <= acc_switch_pkg::SEL_RESET_VALUE;
            sel_ff    <= acc_switch_pkg::SEL_RESET_VALUE;
            vb_sync_ff <= 3'h0;
            ct_sync_ff <= 3'h0;
            ch_sync_ff <= 3'h0;
            vbus_ff    <= 1'b0;
            contact_ff <= 1'b0;
            chport_ff  <= 1'b0;
        end else begin
            sel_s1_ff <= link.sel;
            sel_s2_ff <= sel_s1_ff;
            sel_s3_ff <= sel_s2_ff;
            if (sel_s2_ff == sel_s3_ff) begin
                sel_ff <= sel_s3_ff;
            end
            vb_sync_ff <= {vb_sync_ff[1:0], vbus_valid};
            ct_sync_ff <= {ct_sync_ff[1:0], contact_seen};
            ch_sync_ff <= {ch_sync_ff[1:0], charger_port_seen};
            if (vb_sync_ff[1] == vb_sync_ff[2]) begin
                vbus_ff <= vb_sync_ff[2];
            end
            if (ct_sync_ff[1] == ct_sync_ff[2]) begin
                contact_ff <= ct_sync_ff[2];
            end
            if (ch_sync_ff[1] == ch_sync_ff[2]) begin
                chport_ff <= ch_sync_ff[2];
            end
        end
    end

    // ------------------------------------------------------------
    // select hold timer
    // ------------------------------------------------------------
    // restarts on any code change; held_ff marks a full interval
    always_ff @(posedge clock) begin
        if (reset) begin
            hold_cnt_ff <= '0;
            held_ff     <= 1'b0;
        end else if (sel_ff != sel_s3_ff && sel_s2_ff == sel_s3_ff) begin
            hold_cnt_ff <= '0; // R23
            held_ff     <= 1'b0;
        end else if (hold_cnt_ff
                     == acc_switch_pkg::CNT_W'(acc_switch_pkg::HOLD_CYCLES - 1))
        begin
            held_ff <= 1'b1; // R23
        end else begin
            hold_cnt_ff <= hold_cnt_ff + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // charger detection machine
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            state_ff   <= acc_switch_pkg::DET_IDLE;
            deb_cnt_ff <= '0;
            found_ff   <= 1'b0;
        end else if (sel_ff == acc_switch_pkg::SEL_DET_RESET && held_ff) begin
            state_ff   <= acc_switch_pkg::DET_DISARMED; // R10
            deb_cnt_ff <= '0;
            found_ff   <= 1'b0;
        end else begin
            unique case (state_ff)
                acc_switch_pkg::DET_DISARMED: begin
                    if (sel_ff == acc_switch_pkg::SEL_OPEN && held_ff) begin
                        state_ff <= acc_switch_pkg::DET_IDLE; // R11
                    end
                end
                acc_switch_pkg::DET_IDLE: begin
                    deb_cnt_ff <= '0;
                    // R2 R5
                    if (vbus_ff && sel_ff == acc_switch_pkg::SEL_OPEN) begin
                        state_ff <= acc_switch_pkg::DET_CONTACT;
                    end
                end
                acc_switch_pkg::DET_CONTACT: begin
                    if (!vbus_ff || sel_ff != acc_switch_pkg::SEL_OPEN) begin
                        state_ff <= acc_switch_pkg::DET_IDLE; // R2 R9
                    end else if (!contact_ff) begin
                        deb_cnt_ff <= '0; // R9
                    end else if (deb_cnt_ff == acc_switch_pkg::CNT_W'(
                                 acc_switch_pkg::DEB_CYCLES - 1)) begin
                        state_ff   <= acc_switch_pkg::DET_TYPE; // R4
                        deb_cnt_ff <= '0;
                    end else begin
                        deb_cnt_ff <= deb_cnt_ff + 1'b1;
                    end
                end
                acc_switch_pkg::DET_TYPE: begin
                    if (!vbus_ff || sel_ff != acc_switch_pkg::SEL_OPEN) begin
                        state_ff <= acc_switch_pkg::DET_IDLE; // R2
                    end else if (deb_cnt_ff == acc_switch_pkg::CNT_W'(
                                 acc_switch_pkg::DEB_CYCLES - 1)) begin
                        found_ff <= chport_ff; // R3
                        state_ff <= acc_switch_pkg::DET_DONE;
                    end else begin
                        deb_cnt_ff <= deb_cnt_ff + 1'b1;
                    end
                end
                acc_switch_pkg::DET_DONE: begin
                    // no self recheck; host re-arms with 111 then 000
                    if (!vbus_ff) begin
                        found_ff <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // usb blocking
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            block_ff <= 1'b0;
        end else if (state_ff == acc_switch_pkg::DET_CONTACT
                     || state_ff == acc_switch_pkg::DET_TYPE) begin
            block_ff <= 1'b1; // R6 R7
        end else if (sel_ff == acc_switch_pkg::SEL_AUDIO
                     || sel_ff == acc_switch_pkg::SEL_MONO_MIC
                     || sel_ff == acc_switch_pkg::SEL_STEREO_MIC
                     || state_ff == acc_switch_pkg::DET_DONE
                     || !vbus_ff) begin
            block_ff <= 1'b0; // R8
        end
    end

    // ------------------------------------------------------------
    // path decode
    // ------------------------------------------------------------
    always_comb begin
        nxt_path = '0;
        unique case (sel_ff)
            acc_switch_pkg::SEL_USB_A:
                nxt_path[acc_switch_pkg::P_USB_A] = !block_ff; // R16 R7
            acc_switch_pkg::SEL_USB_B:
                nxt_path[acc_switch_pkg::P_USB_B] = !block_ff; // R17 R7
            acc_switch_pkg::SEL_AUDIO: begin
                nxt_path[acc_switch_pkg::P_R_PLUS]  = 1'b1; // R18
                nxt_path[acc_switch_pkg::P_L_MINUS] = 1'b1;
            end
            acc_switch_pkg::SEL_MONO_MIC: begin
                nxt_path[acc_switch_pkg::P_MIC_PLUS] = 1'b1; // R19
                nxt_path[acc_switch_pkg::P_L_MINUS]  = 1'b1;
            end
            acc_switch_pkg::SEL_STEREO_MIC: begin
                nxt_path[acc_switch_pkg::P_R_PLUS]   = 1'b1; // R20
                nxt_path[acc_switch_pkg::P_L_MINUS]  = 1'b1;
                nxt_path[acc_switch_pkg::P_MIC_VBUS] = 1'b1;
            end
            // 000 opens all; 110 and 111 treated as open
            default: nxt_path = '0; // R15
        endcase
        // audio lines are terminated to ground when both lines are open
        if (!nxt_path[acc_switch_pkg::P_R_PLUS]
            && !nxt_path[acc_switch_pkg::P_L_MINUS]) begin
            nxt_path[acc_switch_pkg::P_TERM] = 1'b1; // R22
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            path_en     <= acc_switch_pkg::PATH_RESET;
            detect_busy <= 1'b0;
            low_power   <= 1'b0;
            link.charger_found_n_o  <= 1'b0;
            link.charger_found_n_oe <= 1'b0;
        end else begin
            path_en     <= nxt_path;
            detect_busy <= block_ff;
            low_power   <= (sel_ff == acc_switch_pkg::SEL_OPEN); // R15
            link.charger_found_n_o  <= 1'b0;
            link.charger_found_n_oe <= found_ff; // R1 R3
        end
    end
endmodule // acc_switch_dev

// ---- logic/acc_switch_host.sv ----
// host side: drives select codes, re-arm sequence, port moves
`timescale 1ns/1ps
module acc_switch_host (
    input  wire logic       clock,
    input  wire logic       reset,
    acc_switch_if.host      link,
    input  wire logic [2:0] want_sel,
    input  wire logic       want_valid,
    input  wire logic       rearm,
    output logic            busy,
    output logic            charger_found
);
    typedef enum logic [2:0] {
        H_IDLE, H_OPEN_GAP, H_RESET_HOLD, H_OPEN_HOLD, H_AUDIO_STEP
    } host_state_t;
    host_state_t state_ff;
    logic [2:0]  sel_ff, target_ff;
    logic [acc_switch_pkg::CNT_W-1:0] cnt_ff;
    logic [2:0]  cf_sync_ff;
    logic        done;

    assign done = (cnt_ff == acc_switch_pkg::CNT_W'(
                   acc_switch_pkg::HOLD_CYCLES));
    assign link.sel = sel_ff;

    // ------------------------------------------------------------
    // indicator sampling
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            cf_sync_ff    <= 3'h7;
            charger_found <= 1'b0;
        end else begin
            cf_sync_ff <= {cf_sync_ff[1:0], link.charger_found_n};
            if (cf_sync_ff[1] == cf_sync_ff[2]) begin
                charger_found <= !cf_sync_ff[2];
            end
        end
    end

    // ------------------------------------------------------------
    // select sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            state_ff  <= H_IDLE;
            sel_ff    <= acc_switch_pkg::SEL_RESET_VALUE;
            target_ff <= acc_switch_pkg::SEL_RESET_VALUE;
            cnt_ff    <= '0;
            busy      <= 1'b0;
        end else begin
            cnt_ff <= done ? cnt_ff : cnt_ff + 1'b1;
            unique case (state_ff)
                H_IDLE: begin
                    busy <= 1'b0;
                    if (rearm) begin
                        sel_ff   <= acc_switch_pkg::SEL_DET_RESET; // R12 R10
                        cnt_ff   <= '0;
                        busy     <= 1'b1;
                        state_ff <= H_RESET_HOLD;
                    end else if (want_valid
                                 && want_sel != acc_switch_pkg::SEL_RESERVED
                                 && want_sel != acc_switch_pkg::SEL_DET_RESET
                                 && want_sel != sel_ff) begin // R21
                        target_ff <= want_sel;
                        busy      <= 1'b1;
                        cnt_ff    <= '0;
                        sel_ff    <= acc_switch_pkg::SEL_OPEN; // R14
                        state_ff  <= H_OPEN_GAP;
                    end
                end
                H_RESET_HOLD: if (done) begin
                    sel_ff   <= acc_switch_pkg::SEL_OPEN; // R12
                    cnt_ff   <= '0;
                    state_ff <= H_OPEN_HOLD;
                end
                H_OPEN_HOLD: if (done) begin
                    state_ff <= H_IDLE; // R13
                end
                H_OPEN_GAP: if (done) begin
                    cnt_ff <= '0;
                    if (target_ff == acc_switch_pkg::SEL_USB_A
                        || target_ff == acc_switch_pkg::SEL_USB_B) begin
                        sel_ff   <= acc_switch_pkg::SEL_AUDIO; // R8
                        state_ff <= H_AUDIO_STEP;
                    end else begin
                        sel_ff   <= target_ff;
                        state_ff <= H_IDLE;
                    end
                end
                H_AUDIO_STEP: if (done) begin
                    sel_ff   <= target_ff; // R8
                    state_ff <= H_IDLE;
                end
                default: state_ff <= H_IDLE;
            endcase
        end
    end
endmodule // acc_switch_host

// ---- verif/acc_switch_monitor.sv ----
// assertions on the select and indicator wires and the device outputs
`timescale 1ns/1ps
module acc_switch_monitor (
    input wire logic       clock,
    input wire logic       reset,
    input wire logic [2:0] sel,
    input wire logic       charger_found_n_o,
    input wire logic       charger_found_n_oe,
    input wire logic       charger_found_n,
    input wire logic       vbus_valid,
    input wire logic [6:0] path_en,
    input wire logic       detect_busy,
    input wire logic       low_power
);
    // ----------------------------------------
    // helper: cycles spent in the reset code
    // ----------------------------------------
    logic [11:0] rst_cnt_ff;
    logic [11:0] nxt_rst_cnt;
    // saturates so a long hold cannot wrap back below the limit
    assign nxt_rst_cnt = (sel != 3'h7) ? 12'h000 :
                         (rst_cnt_ff == 12'hFFF) ? rst_cnt_ff :
                         rst_cnt_ff + 12'h001;
    always_ff @(posedge clock) begin
        if (reset) begin
            rst_cnt_ff <= 12'h000;
        end else begin
            rst_cnt_ff <= nxt_rst_cnt;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    property p_drive_low;
        charger_found_n_oe |-> !charger_found_n_o && !charger_found_n;
    endproperty
    a_drive_low: assert property (p_drive_low)
        else $error("indicator enabled but line not low");
    property p_vbus_loss;
        $fell(vbus_valid) |-> ##[1:8] !charger_found_n_oe;
    endproperty
    a_vbus_loss: assert property (p_vbus_loss)
        else $error("indicator kept after vbus loss");
    // audio codes may close while blocked: they are the override path
    property p_busy_open;
        detect_busy |-> path_en[1:0] == 2'b00;
    endproperty
    a_busy_open: assert property (p_busy_open)
        else $error("path closed during detection");
    property p_busy_start;
        // pin code seven samples back feeds the filtered code
        $rose(detect_busy) |-> $past(sel, 7) == 3'h0;
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("detection started outside open code");
    property p_low_power;
        low_power [*3] |-> path_en == 7'h40;
    endproperty
    a_low_power: assert property (p_low_power)
        else $error("low power with a path closed");
    property p_usb_b;
        $changed(sel) && sel == 3'h2 && !detect_busy |-> ##5 path_en == 7'h42;
    endproperty
    a_usb_b: assert property (p_usb_b)
        else $error("second usb path wrong");
    property p_audio;
        $changed(sel) && sel == 3'h3 |-> ##5 path_en == 7'h0C;
    endproperty
    a_audio: assert property (p_audio)
        else $error("audio path wrong");
    property p_mono;
        $changed(sel) && sel == 3'h4 |-> ##5 path_en == 7'h18;
    endproperty
    a_mono: assert property (p_mono)
        else $error("mono path wrong");
    property p_stereo;
        $changed(sel) && sel == 3'h5 |-> ##5 path_en == 7'h2C;
    endproperty
    a_stereo: assert property (p_stereo)
        else $error("stereo path wrong");
    property p_term;
        path_en[3:2] == 2'b00 |-> path_en[6];
    endproperty
    a_term: assert property (p_term)
        else $error("open audio lines not terminated");
    property p_det_reset;
        rst_cnt_ff >= 12'd1201 && sel != 3'h7
            |-> ##[1:8] !charger_found_n_oe;
    endproperty
    a_det_reset: assert property (p_det_reset)
        else $error("indicator kept after reset code hold");
    c_detect: cover property ($rose(detect_busy));
    c_found: cover property ($rose(charger_found_n_oe));
    c_reset_code: cover property (rst_cnt_ff == 12'd1201);
endmodule // acc_switch_monitor

// ---- verif/testbench.sv ----
// self-checking bench joining host and device ends
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, b); end end
module testbench;
    logic       clock = 1'b0;
    logic       reset = 1'b1;
    logic       vbus_valid = 1'b0;
    logic       contact_seen = 1'b0;
    logic       charger_port_seen = 1'b0;
    logic [2:0] want_sel = 3'h1;
    logic       want_valid = 1'b0;
    logic       rearm = 1'b0;
    logic [6:0] path_en;
    logic       detect_busy;
    logic       low_power;
    logic       busy;
    logic       charger_found;
    int         n_mismatch = 0;
    int         num_checks = 0;
    logic [2:0] codes [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h1};
    logic [6:0] paths [6] = '{7'h40, 7'h42, 7'h0C, 7'h18, 7'h2C, 7'h41};
    always #12.5 clock = ~clock;
    acc_switch_if link_if ();
    acc_switch_dev acc_switch_dev_i (
        .clock             (clock),
        .reset             (reset),
        .link              (link_if),
        .vbus_valid        (vbus_valid),
        .contact_seen      (contact_seen),
        .charger_port_seen (charger_port_seen),
        .path_en           (path_en),
        .detect_busy       (detect_busy),
        .low_power         (low_power)
    );
    acc_switch_host acc_switch_host_i (
        .clock         (clock),
        .reset         (reset),
        .link          (link_if),
        .want_sel      (want_sel),
        .want_valid    (want_valid),
        .rearm         (rearm),
        .busy          (busy),
        .charger_found (charger_found)
    );
    acc_switch_monitor acc_switch_monitor_i (
        .clock              (clock),
        .reset              (reset),
        .sel                (link_if.sel),
        .charger_found_n_o  (link_if.charger_found_n_o),
        .charger_found_n_oe (link_if.charger_found_n_oe),
        .charger_found_n    (link_if.charger_found_n),
        .vbus_valid         (vbus_valid),
        .path_en            (path_en),
        .detect_busy        (detect_busy),
        .low_power          (low_power)
    );
    // ----------------------------------------
    // host requests
    // ----------------------------------------
    // request is held until the host shows busy, then released
    task automatic request(input logic [2:0] code, input logic re);
        @(posedge clock);
        want_sel <= code;
        want_valid <= !re;
        rearm <= re;
        for (int i = 0; i < 20 && busy !== 1'b1; i++) @(posedge clock);
        want_valid <= 1'b0;
        rearm <= 1'b0;
        for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(posedge clock);
        repeat (10) @(posedge clock);
    endtask
    task automatic wait_found(input int n);
        for (int i = 0; i < n && charger_found !== 1'b1; i++) @(posedge clock);
        repeat (4) @(posedge clock);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        repeat (20) @(posedge clock);
        `CHK(path_en, 7'h41)
        for (int k = 0; k < 6; k++) begin
            request(codes[k], 1'b0);
            `CHK(path_en, paths[k])
            `CHK(low_power, codes[k] == 3'h0)
        end
        $display("test routes done");
        vbus_valid <= 1'b1;
        contact_seen <= 1'b1;
        charger_port_seen <= 1'b1;
        request(3'h0, 1'b0);
        wait_found(4000);
        `CHK(charger_found, 1'b1)
        `CHK(link_if.charger_found_n, 1'b0)
        request(3'h0, 1'b1);
        `CHK(charger_found, 1'b0)
        wait_found(4000);
        `CHK(charger_found, 1'b1)
        vbus_valid <= 1'b0;
        repeat (12) @(posedge clock);
        `CHK(charger_found, 1'b0)
        $display("test detect done");
        // no contact: detection holds the usb paths off
        contact_seen <= 1'b0;
        vbus_valid <= 1'b1;
        request(3'h0, 1'b1);
        repeat (1000) @(posedge clock);
        `CHK(detect_busy, 1'b1)
        `CHK(path_en, 7'h40)
        request(3'h1, 1'b0);
        `CHK(path_en, 7'h41)
        `CHK(detect_busy, 1'b0)
        $display("test blocking done");
        // short vbus bounces must not end in a detection
        vbus_valid <= 1'b0;
        contact_seen <= 1'b1;
        request(3'h0, 1'b1);
        repeat (5) begin
            vbus_valid <= 1'b1;
            repeat (100) @(posedge clock);
            vbus_valid <= 1'b0;
            repeat (100) @(posedge clock);
        end
        `CHK(charger_found, 1'b0)
        charger_port_seen <= 1'b0;
        vbus_valid <= 1'b1;
        request(3'h0, 1'b1);
        repeat (3000) @(posedge clock);
        `CHK(charger_found, 1'b0)
        `CHK(detect_busy, 1'b0)
        $display("test glitch done");
        tally_and_finish();
    end
    initial begin
        #(25ns * 95000);
        n_mismatch++;
        $display("[FAIL] t=%0t got=%0h exp=%0h", $time, 1'b0, 1'b1);
        tally_and_finish();
    end
endmodule // testbench
